// ===== logic/pcsc_regs.vh
`ifndef PCSC_REGS_VH
`define PCSC_REGS_VH

// Register byte offsets
`define PCSC_OFS_SUPPRESS  6'h00
`define PCSC_OFS_CLIP      6'h04
`define PCSC_OFS_TBL_ADDR  6'h08
`define PCSC_OFS_TBL_DATA  6'h0c
`define PCSC_OFS_TBL_SEL   6'h10
`define PCSC_OFS_STATUS    6'h14

// Suppression settings fields
`define PCSC_HPF_BIT       16
`define PCSC_TH_MSB        15
`define PCSC_TH_LSB        8
`define PCSC_GAIN_MSB      7
`define PCSC_GAIN_LSB      0

// Clip limit fields
`define PCSC_YMAX_MSB      31
`define PCSC_YMAX_LSB      24
`define PCSC_YMIN_MSB      23
`define PCSC_YMIN_LSB      16
`define PCSC_CMAX_MSB      15
`define PCSC_CMAX_LSB      8
`define PCSC_CMIN_MSB      7
`define PCSC_CMIN_LSB      0

// Reset values
`define PCSC_SUPPRESS_RST  32'h0000_0000
`define PCSC_CLIP_RST      32'hff00_ff00
`define PCSC_TBL_ADDR_RST  13'h0000

// Table address and data widths
`define PCSC_TADDR_W       13
`define PCSC_TDATA_W       20
`define PCSC_TDEPTH        8192

// Table select codes
`define PCSC_TBL_NLE       2'h0
`define PCSC_TBL_GAMMA     2'h1
`define PCSC_TBL_NF        2'h2
`define PCSC_TBL_CFA       2'h3

`endif

// ===== logic/pcsc_tbl_mem.v
module pcsc_tbl_mem (
  // Clock
  input  wire        clk_i,
  // Write port
  input  wire        we_i,
  input  wire [12:0] waddr_i,
  input  wire [19:0] wdata_i,
  // Read port
  input  wire [12:0] raddr_i,
  output reg  [19:0] rdata_o
);

  reg [19:0] mem [0:8191];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// ===== logic/pcsc_clip.v
module pcsc_clip (
  // Sample and limits
  input  wire [7:0] val_i,
  input  wire [7:0] upper_i,
  input  wire [7:0] lower_i,
  // Clipped sample
  output reg  [7:0] val_o
);

  always @* begin
    if (val_i > upper_i) begin
      val_o = upper_i;
    end else if (val_i < lower_i) begin
      val_o = lower_i;
    end else begin
      val_o = val_i;
    end
  end

endmodule

// ===== logic/pcsc_top.v
`include "pcsc_regs.vh"

module pcsc_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // Pixel input
  input  wire        pix_valid_i,
  input  wire [7:0]  pix_y_i,
  input  wire [7:0]  pix_y_hpf_i,
  input  wire [7:0]  pix_cb_i,
  input  wire [7:0]  pix_cr_i,
  // Pixel output
  output reg         pix_valid_o,
  output reg  [7:0]  pix_y_o,
  output reg  [7:0]  pix_cb_o,
  output reg  [7:0]  pix_cr_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_DONE = 3'b100;

  reg  [31:0] suppress_reg;
  reg  [31:0] clip_reg;
  reg  [12:0] tbl_addr_reg;
  reg  [1:0]  tbl_sel_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [31:0] pix_count_reg;

  reg  [7:0]  s1_y_reg;
  reg  [7:0]  s1_cb_reg;
  reg  [7:0]  s1_cr_reg;
  reg         s1_valid_reg;

  wire        req;
  wire        tbl_data_hit;
  wire        tbl_we;
  wire [19:0] tbl_wdata;
  wire [19:0] tbl_rdata;
  wire [7:0]  y_clip;
  wire [7:0]  cb_clip;
  wire [7:0]  cr_clip;

  assign req = wb_cyc_i & wb_stb_i & state_reg[0];

  // Byte-lane merge of a write onto an old register value
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // Known register offset
  function is_mapped;
    input [5:0] a;
    begin
      is_mapped = (a == `PCSC_OFS_SUPPRESS) || (a == `PCSC_OFS_CLIP) ||
                  (a == `PCSC_OFS_TBL_ADDR) || (a == `PCSC_OFS_TBL_DATA) ||
                  (a == `PCSC_OFS_TBL_SEL)  || (a == `PCSC_OFS_STATUS);
    end
  endfunction

  assign tbl_data_hit = req & (wb_adr_i == `PCSC_OFS_TBL_DATA);
  assign tbl_we       = tbl_data_hit & wb_we_i;

  // Enhancer keeps all 20 bits, other tables only the low byte
  assign tbl_wdata = (tbl_sel_reg == `PCSC_TBL_NLE) ?
                     wb_dat_i[19:0] :
                     {12'h000, wb_dat_i[7:0]};

  pcsc_tbl_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (tbl_we),
    .waddr_i ({tbl_sel_reg, tbl_addr_reg[10:0]}),
    .wdata_i (tbl_wdata),
    .raddr_i ({tbl_sel_reg, tbl_addr_reg[10:0]}),
    .rdata_o (tbl_rdata)
  );

  // Bus state machine: table reads need one extra cycle
  always @* begin
    case (state_reg)
      ST_IDLE: begin
        if (req && !wb_we_i && wb_adr_i == `PCSC_OFS_TBL_DATA) begin
          state_next = ST_READ;
        end else if (req) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_READ: state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      suppress_reg <= `PCSC_SUPPRESS_RST;
      clip_reg     <= `PCSC_CLIP_RST;
      tbl_addr_reg <= `PCSC_TBL_ADDR_RST;
      tbl_sel_reg  <= `PCSC_TBL_NLE;
      wb_ack_o     <= 1'b0;
      wb_err_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      wb_ack_o  <= 1'b0;
      wb_err_o  <= 1'b0;
      if (state_reg == ST_READ) begin
        wb_ack_o <= 1'b1;
        wb_dat_o <= {12'h000, tbl_rdata};
      end
      if (req) begin
        if (!is_mapped(wb_adr_i)) begin
          wb_err_o <= 1'b1;
          wb_dat_o <= 32'h0000_0000;
        end else if (wb_we_i) begin
          wb_ack_o <= 1'b1;
          case (wb_adr_i)
            `PCSC_OFS_SUPPRESS: begin
              suppress_reg <= lane_merge(suppress_reg, wb_dat_i,
                                         wb_sel_i) & 32'h0001_ffff;
            end
            `PCSC_OFS_CLIP: begin
              clip_reg <= lane_merge(clip_reg, wb_dat_i, wb_sel_i);
            end
            `PCSC_OFS_TBL_ADDR: begin
              tbl_addr_reg <= wb_dat_i[12:0];
            end
            `PCSC_OFS_TBL_DATA: begin
              // Table write goes straight to the memory
            end
            `PCSC_OFS_TBL_SEL: begin
              tbl_sel_reg <= wb_dat_i[1:0];
            end
            default: begin
            end
          endcase
        end else if (wb_adr_i != `PCSC_OFS_TBL_DATA) begin
          wb_ack_o <= 1'b1;
          case (wb_adr_i)
            `PCSC_OFS_SUPPRESS: wb_dat_o <= suppress_reg;
            `PCSC_OFS_CLIP:     wb_dat_o <= clip_reg;
            `PCSC_OFS_TBL_ADDR: wb_dat_o <= {19'h00000, tbl_addr_reg};
            `PCSC_OFS_TBL_SEL:  wb_dat_o <= {30'h0, tbl_sel_reg};
            `PCSC_OFS_STATUS:   wb_dat_o <= pix_count_reg;
            default:            wb_dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Chroma suppression: luma source, threshold and gain
  wire [7:0]  supp_luma;
  wire [7:0]  supp_th;
  wire [7:0]  supp_gain;
  wire [7:0]  excess;
  wire [15:0] atten;
  wire [7:0]  keep_q8;

  assign supp_luma = suppress_reg[`PCSC_HPF_BIT] ?
                     pix_y_hpf_i : pix_y_i;
  assign supp_th   = suppress_reg[`PCSC_TH_MSB:`PCSC_TH_LSB];
  assign supp_gain = suppress_reg[`PCSC_GAIN_MSB:`PCSC_GAIN_LSB];
  assign excess    = (supp_luma > supp_th) ? (supp_luma - supp_th) :
                     8'h00;
  assign atten     = excess * supp_gain;
  assign keep_q8   = (atten[15:8] != 8'h00) ? 8'h00 : ~atten[7:0];

  // Pull chroma toward neutral 0x80 by the keep factor
  function [7:0] suppress_c;
    input [7:0] c;
    input [7:0] keep;
    reg   [8:0]  dev;
    reg   [16:0] prod;
    begin
      dev        = {1'b0, c} - 9'h080;
      prod       = $signed(dev) * $signed({1'b0, keep});
      suppress_c = prod[15:8] + 8'h80;
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_valid_reg <= 1'b0;
      s1_y_reg     <= 8'h00;
      s1_cb_reg    <= 8'h80;
      s1_cr_reg    <= 8'h80;
    end else begin
      s1_valid_reg <= pix_valid_i;
      if (pix_valid_i) begin
        s1_y_reg  <= pix_y_i;
        s1_cb_reg <= suppress_c(pix_cb_i, keep_q8);
        s1_cr_reg <= suppress_c(pix_cr_i, keep_q8);
      end
    end
  end

  // Output clipping; each component has its own comparator pair
  pcsc_clip u_clip_y (
    .val_i   (s1_y_reg),
    .upper_i (clip_reg[`PCSC_YMAX_MSB:`PCSC_YMAX_LSB]),
    .lower_i (clip_reg[`PCSC_YMIN_MSB:`PCSC_YMIN_LSB]),
    .val_o   (y_clip)
  );

  pcsc_clip u_clip_cb (
    .val_i   (s1_cb_reg),
    .upper_i (clip_reg[`PCSC_CMAX_MSB:`PCSC_CMAX_LSB]),
    .lower_i (clip_reg[`PCSC_CMIN_MSB:`PCSC_CMIN_LSB]),
    .val_o   (cb_clip)
  );

  pcsc_clip u_clip_cr (
    .val_i   (s1_cr_reg),
    .upper_i (clip_reg[`PCSC_CMAX_MSB:`PCSC_CMAX_LSB]),
    .lower_i (clip_reg[`PCSC_CMIN_MSB:`PCSC_CMIN_LSB]),
    .val_o   (cr_clip)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      pix_valid_o   <= 1'b0;
      pix_y_o       <= 8'h00;
      pix_cb_o      <= 8'h80;
      pix_cr_o      <= 8'h80;
      pix_count_reg <= 32'h0000_0000;
    end else begin
      pix_valid_o <= s1_valid_reg;
      if (s1_valid_reg) begin
        pix_y_o       <= y_clip;
        pix_cb_o      <= cb_clip;
        pix_cr_o      <= cr_clip;
        pix_count_reg <= pix_count_reg + 32'h0000_0001;
      end
    end
  end

endmodule

// ===== dv/pcsc_top_props.sv
module pcsc_props (
  // Clock and reset
  input logic        clk_i,
  input logic        rst_i,
  // Bus
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [5:0]  wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic        wb_ack_o,
  input logic        wb_err_o,
  // Pixels
  input logic        pix_valid_i,
  input logic        pix_valid_o,
  input logic [7:0]  pix_y_o,
  input logic [7:0]  pix_cb_o,
  input logic [7:0]  pix_cr_o
);
  logic [31:0] lim_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the clip limits, full-word writes only
  always_ff @(posedge clk_i)
    if (rst_i)
      lim_reg <= 32'hff00ff00;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 6'h04)
      lim_reg <= wb_dat_i;
  sequence s_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reg_ack: assert property (s_req ##0
    (wb_adr_i <= 6'h14 && (wb_we_i || wb_adr_i != 6'h0c)) |=> wb_ack_o)
    else $error("register access not acked in one cycle");
  a_tbl_read: assert property (s_req ##0 (!wb_we_i && wb_adr_i == 6'h0c)
    |=> !wb_ack_o ##1 wb_ack_o)
    else $error("table read not acked after two cycles");
  a_unmapped_err: assert property (s_req ##0 (wb_adr_i > 6'h14)
    |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_pix_latency: assert property (pix_valid_i |-> ##2 pix_valid_o)
    else $error("pixel output late");
  a_pix_cause: assert property (pix_valid_o |-> $past(pix_valid_i, 2))
    else $error("pixel output without input");
  a_pix_hold: assert property (!pix_valid_o && !$past(rst_i)
    |-> $stable({pix_y_o, pix_cb_o, pix_cr_o}))
    else $error("pixel output changed between valids");
  a_luma_clip: assert property (pix_valid_o |->
    pix_y_o <= lim_reg[31:24] && pix_y_o >= lim_reg[23:16])
    else $error("luma outside limits");
  a_chroma_clip: assert property (pix_valid_o |->
    pix_cb_o <= lim_reg[15:8] && pix_cb_o >= lim_reg[7:0] &&
    pix_cr_o <= lim_reg[15:8] && pix_cr_o >= lim_reg[7:0])
    else $error("chroma outside limits");
endmodule

bind pcsc_top pcsc_props i_pcsc_props (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_err_o,
  .pix_valid_i, .pix_valid_o, .pix_y_o, .pix_cb_o, .pix_cr_o);

// ===== dv/test_pcsc_top.sv
module test_pcsc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        req = 0, we = 0, pv = 0, ack, err, vo, e;
  logic [5:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [7:0]  y = 0, yh = 0, cb = 0, cr = 0, yo, cbo, cro;
  int          err_total = 0, num_checks = 0, cyc_cnt = 0, npix = 0;

  pcsc_top i_pcsc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .pix_valid_i(pv), .pix_y_i(y), .pix_y_hpf_i(yh), .pix_cb_i(cb),
    .pix_cr_i(cr), .pix_valid_o(vo), .pix_y_o(yo), .pix_cb_o(cbo),
    .pix_cr_o(cro));

  always #25 clk_i = ~clk_i;

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Request held until the rising edge that samples ack or err high
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    req <= 1; we <= w; adr <= a; wdat <= d; sel <= s;
    do @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    req <= 0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    wb(0, a, 0, 4'hf);
    chk(q, x);
  endtask

  // Input packs y, highpass y, cb, cr; expectation packs y, cb, cr
  task automatic px(input logic [31:0] in, input logic [23:0] x);
    @(posedge clk_i);
    pv <= 1; {y, yh, cb, cr} <= in;
    @(posedge clk_i);
    pv <= 0;
    // Output stands for one cycle; this edge still sees it
    repeat (2) @(posedge clk_i);
    chk({vo, yo, cbo, cro}, {1'b1, x});
    npix++;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      err_total++;
      stop_test;
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rd(6'h00, 0);
    rd(6'h04, 32'hff00ff00);
    rd(6'h08, 0);
    wr(6'h00, 32'h000040ff);
    px(32'h30f0f010, 24'h30ef10);
    wr(6'h00, 32'hfffe40ff);
    rd(6'h00, 32'h000040ff);
    wr(6'h00, 32'h000140ff);
    px(32'h30f0f010, 24'h308080);
    wb(1, 6'h00, 32'hffff0000, 4'h2);
    rd(6'h00, 32'h000100ff);
    wr(6'h00, 0);
    wr(6'h04, 32'hc020b030);
    rd(6'h04, 32'hc020b030);
    px(32'hf000f010, 24'hc0b030);
    px(32'h100010f0, 24'h2030b0);
    px(32'h80008080, 24'h808080);
    wr(6'h10, 0);
    wr(6'h08, 32'h123);
    wr(6'h0c, 32'hfabcde);
    rd(6'h0c, 32'habcde);
    wr(6'h08, 32'h124);
    wr(6'h0c, 32'h55);
    wr(6'h08, 32'h123);
    rd(6'h0c, 32'habcde);
    rd(6'h08, 32'h123);
    for (int t = 1; t < 4; t++) begin
      wr(6'h10, 32'(t));
      wr(6'h0c, 32'hfffff);
      rd(6'h0c, 32'hff);
    end
    rd(6'h10, 3);
    wb(0, 6'h18, 0, 4'hf);
    chk(e, 1);
    chk(q, 0);
    rd(6'h14, npix);
    stop_test;
  end
endmodule
